// ==== logic/i2cie_evsync.sv ====
`timescale 1ns/1ps
// Carries one-cycle link events into the module clock by toggles
module i2cie_evsync
    import i2cie_pkg::*;
(
    input wire logic lclk, // Link clock
    input wire logic mclk, // Module clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [NUM_EV-1:0] ev_in, // Event pulses, link domain
    output logic [NUM_EV-1:0] ev_pulse // Event pulses, module domain
);
    logic [NUM_EV-1:0] tog_q;
    logic [NUM_EV-1:0] tog_d;
    logic [NUM_EV-1:0] s1_q;
    logic [NUM_EV-1:0] s2_q;
    logic [NUM_EV-1:0] s3_q;

    // Each event flips its own toggle in the link domain
    always_comb
    begin
        tog_d = tog_q ^ ev_in;
    end

    always_ff @(posedge lclk or negedge arst_n)
    begin
        if (!arst_n)
            tog_q <= '0;
        else
            tog_q <= tog_d;
    end

    // Three stages; the first is read only by the second
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= tog_q;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change counts once stages two and three disagree
    genvar i;
    generate
        for (i = 0; i < NUM_EV; i++)
        begin : g_edge
            assign ev_pulse[i] = s2_q[i] ^ s3_q[i];
        end
    endgenerate
endmodule

// ==== logic/i2cie_pkg.sv ====
package i2cie_pkg;
    // Register indices on the I/O port
    localparam logic [3:0] IER_OFS = 4'h0;
    localparam logic [3:0] STR_OFS = 4'h1;
    localparam logic [3:0] ISRC_OFS = 4'h2;
    // Status bit positions
    localparam int ST_NACK_SENT = 13;
    localparam int ST_BUS_BUSY = 12;
    localparam int ST_RX_OVERRUN = 11;
    localparam int ST_TX_NOT_EMPTY = 10;
    localparam int ST_ADDRESSED = 9;
    localparam int ST_GEN_CALL = 8;
    localparam int ST_TX_READY = 4;
    localparam int ST_RX_READY = 3;
    localparam int ST_ACC_READY = 2;
    localparam int ST_NOACK = 1;
    localparam int ST_ARB_LOST = 0;
    // Masks and reset values
    localparam logic [15:0] IER_MASK = 16'h001f;
    localparam logic [15:0] STR_MASK = 16'h3f1f;
    localparam logic [15:0] STR_W1C_MASK = 16'h301f;
    localparam logic [15:0] STR_RESET = 16'h0410;
    localparam logic [4:0] IER_RESET = 5'h00;
    // Interrupt source codes
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ARB = 3'h1;
    localparam logic [2:0] CODE_NOACK = 3'h2;
    localparam logic [2:0] CODE_ACC = 3'h3;
    localparam logic [2:0] CODE_RX = 3'h4;
    localparam logic [2:0] CODE_TX = 3'h5;
    // Link event indices
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_NACK_SENT = 2;
    localparam int EV_ACK_RX = 3;
    localparam int EV_NACK_RX = 4;
    localparam int EV_OWN_ADDR = 5;
    localparam int EV_GCALL_ADDR = 6;
    localparam int EV_FREE_FIRST = 7;
    localparam int EV_ADDR_DIFF = 8;
    localparam int EV_RX_BYTE = 9;
    localparam int EV_TX_EMPTY = 10;
    localparam int EV_CNT_ZERO = 11;
    localparam int EV_TX_BYTE_END = 12;
    localparam int EV_ARB_LOST = 13;
    localparam int EV_REG_USE = 14;
    localparam int NUM_EV = 15;
endpackage

// ==== logic/i2cie_top.sv ====
`timescale 1ns/1ps
// Interrupt enable and status flags of the two-wire controller
module i2cie_top
    import i2cie_pkg::*;
(
    input wire logic mclk, // Module clock, 250 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic lclk, // Link-side clock
    input wire logic [3:0] io_addr, // Register index
    input wire logic io_wr, // Register write strobe
    input wire logic io_rd, // Register read strobe
    input wire logic [15:0] io_wdata, // Write data
    output logic [15:0] io_rdata_q, // Read data, valid after read
    input wire logic module_enable, // Module out of reset
    input wire logic master_mode, // Master mode active
    input wire logic repeat_mode, // Repeat mode active
    input wire logic stop_request, // Stop request set
    input wire logic addr_10bit, // Ten-bit addressing
    input wire logic gc_xfer, // General call transfer running
    input wire logic start_req, // Start attempt pulse
    input wire logic tx_data_wr, // Transmit data register written
    input wire logic rx_data_rd, // Receive data register read
    input wire logic lk_start, // START seen or sent
    input wire logic lk_stop, // STOP seen or sent
    input wire logic lk_nack_sent, // We sent a NACK
    input wire logic lk_ack_rx, // ACK received
    input wire logic lk_nack_rx, // NACK received
    input wire logic lk_own_addr, // Own address matched
    input wire logic lk_gcall_addr, // All-zero address seen
    input wire logic lk_free_first, // First free-format byte in
    input wire logic lk_addr_diff, // Other ten-bit address seen
    input wire logic lk_rx_byte, // Byte complete in rx shift
    input wire logic lk_tx_empty, // Tx shift register empty
    input wire logic lk_cnt_zero, // Data counter reached zero
    input wire logic lk_tx_byte_end, // Byte sent from tx data
    input wire logic lk_arb_lost, // Arbitration lost
    input wire logic lk_reg_use, // Engine takes register contents
    output logic irq_q, // Interrupt request
    output logic rx_copy_q, // Move rx shift into rx data
    output logic tx_copy_q, // Move tx data into tx shift
    output logic tx_hold_q, // Withhold next transfer
    output logic stop_gen_q, // Generate STOP
    output logic mst_clr_q // Clear master and stop request
);
    logic [NUM_EV-1:0] lk_ev;
    logic [NUM_EV-1:0] ev;
    logic [4:0] ier_q;
    logic [4:0] ier_d;
    logic [15:0] str_q;
    logic [15:0] str_d;
    logic tx_loaded_q;
    logic tx_loaded_d;
    logic [15:0] rdata_d;
    logic irq_d;
    logic rx_copy_d;
    logic tx_copy_d;
    logic tx_hold_d;
    logic stop_gen_d;
    logic mst_clr_d;
    logic [15:0] str_view;
    logic [4:0] pend;
    logic [2:0] code;

    // Highest-priority pending enabled source
    function automatic logic [2:0] src_code(input logic [4:0] p);
        logic [2:0] c;
        c = CODE_NONE;
        if (p[ST_ARB_LOST])
            c = CODE_ARB;
        else if (p[ST_NOACK])
            c = CODE_NOACK;
        else if (p[ST_ACC_READY])
            c = CODE_ACC;
        else if (p[ST_RX_READY])
            c = CODE_RX;
        else if (p[ST_TX_READY])
            c = CODE_TX;
        return c;
    endfunction

    assign lk_ev = {lk_reg_use, lk_arb_lost, lk_tx_byte_end, lk_cnt_zero, lk_tx_empty,
                    lk_rx_byte, lk_addr_diff, lk_free_first, lk_gcall_addr, lk_own_addr,
                    lk_nack_rx, lk_ack_rx, lk_nack_sent, lk_stop, lk_start};

    i2cie_evsync u_sync (
        .lclk(lclk),
        .mclk(mclk),
        .arst_n(arst_n),
        .ev_in(lk_ev),
        .ev_pulse(ev)
    );

    // Status as seen by software; general call forces the no-ack bit
    always_comb
    begin
        str_view = str_q & STR_MASK;
        if (gc_xfer)
            str_view[ST_NOACK] = 1'b1;
        pend = ier_q & str_view[4:0];
        code = src_code(pend);
    end

    // Next state of enables, flags and strobes
    always_comb
    begin
        ier_d = ier_q;
        str_d = str_q;
        tx_loaded_d = tx_loaded_q;
        rx_copy_d = 1'b0;
        tx_copy_d = 1'b0;
        tx_hold_d = tx_hold_q;
        stop_gen_d = 1'b0;
        mst_clr_d = 1'b0;
        rdata_d = io_rdata_q;
        if (io_wr && io_addr == IER_OFS)
            ier_d = io_wdata[4:0];
        // Clears first so that any set below wins
        if (io_wr && io_addr == STR_OFS)
            str_d = str_d & ~(io_wdata & STR_W1C_MASK);
        if (ev[EV_STOP])
            str_d[ST_BUS_BUSY] = 1'b0;
        if (ev[EV_START] || ev[EV_STOP])
            str_d[ST_GEN_CALL] = 1'b0;
        if (ev[EV_NACK_RX] || ev[EV_STOP]
            || (!addr_10bit && ev[EV_START] && str_q[ST_BUS_BUSY])
            || (addr_10bit && ev[EV_ADDR_DIFF]))
            str_d[ST_ADDRESSED] = 1'b0;
        if (ev[EV_ACK_RX])
            str_d[ST_NOACK] = 1'b0;
        if (io_rd && io_addr == ISRC_OFS && code == CODE_NOACK)
            str_d[ST_NOACK] = 1'b0;
        if (io_rd && io_addr == ISRC_OFS && code == CODE_ARB)
            str_d[ST_ARB_LOST] = 1'b0;
        if (ev[EV_REG_USE])
            str_d[ST_ACC_READY] = 1'b0;
        if (rx_data_rd)
        begin
            str_d[ST_RX_READY] = 1'b0;
            str_d[ST_RX_OVERRUN] = 1'b0;
        end
        if (tx_data_wr)
            str_d[ST_TX_READY] = 1'b0;
        // Sets
        if (ev[EV_START])
            str_d[ST_BUS_BUSY] = 1'b1;
        if (ev[EV_NACK_SENT])
            str_d[ST_NACK_SENT] = 1'b1;
        if (ev[EV_OWN_ADDR] || ev[EV_GCALL_ADDR] || ev[EV_FREE_FIRST])
            str_d[ST_ADDRESSED] = 1'b1;
        if (ev[EV_GCALL_ADDR])
            str_d[ST_GEN_CALL] = 1'b1;
        if (ev[EV_NACK_RX])
            str_d[ST_NOACK] = 1'b1;
        // A held byte moves over once the old one is read
        if (rx_data_rd && str_q[ST_RX_OVERRUN])
        begin
            str_d[ST_RX_READY] = 1'b1;
            rx_copy_d = 1'b1;
        end
        if (ev[EV_RX_BYTE])
        begin
            if (str_q[ST_RX_READY] && !rx_data_rd)
                str_d[ST_RX_OVERRUN] = 1'b1;
            else
            begin
                str_d[ST_RX_READY] = 1'b1;
                rx_copy_d = 1'b1;
            end
        end
        // Transmit side: copy only fresh data, else starve
        if ((ev[EV_TX_EMPTY] || tx_hold_q) && tx_loaded_q)
        begin
            str_d[ST_TX_READY] = 1'b1;
            str_d[ST_TX_NOT_EMPTY] = 1'b1;
            tx_copy_d = 1'b1;
            tx_loaded_d = 1'b0;
            tx_hold_d = 1'b0;
        end
        else if (ev[EV_TX_EMPTY])
        begin
            str_d[ST_TX_NOT_EMPTY] = 1'b0;
            tx_hold_d = 1'b1;
        end
        if (tx_data_wr)
        begin
            str_d[ST_TX_NOT_EMPTY] = 1'b1;
            tx_loaded_d = 1'b1;
        end
        // Access ready only matters while master
        if (master_mode && ev[EV_CNT_ZERO] && !repeat_mode)
        begin
            if (stop_request)
                stop_gen_d = 1'b1;
            else
                str_d[ST_ACC_READY] = 1'b1;
        end
        if (master_mode && ev[EV_TX_BYTE_END] && repeat_mode)
            str_d[ST_ACC_READY] = 1'b1;
        if (ev[EV_ARB_LOST] || (start_req && str_q[ST_BUS_BUSY]))
        begin
            str_d[ST_ARB_LOST] = 1'b1;
            mst_clr_d = 1'b1;
        end
        // Disabled module sits at defaults; enables are kept
        if (!module_enable)
        begin
            str_d = STR_RESET;
            tx_loaded_d = 1'b0;
            tx_hold_d = 1'b0;
            rx_copy_d = 1'b0;
            tx_copy_d = 1'b0;
            stop_gen_d = 1'b0;
            mst_clr_d = 1'b0;
        end
        str_d = str_d & STR_MASK;
        if (io_rd)
        begin
            unique case (io_addr)
                IER_OFS: rdata_d = {11'h000, ier_q};
                STR_OFS: rdata_d = str_view;
                ISRC_OFS: rdata_d = {13'h0000, code};
                default: rdata_d = 16'h0000;
            endcase
        end
        irq_d = |pend;
    end

    // Registers only
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ier_q <= IER_RESET;
            str_q <= STR_RESET;
            tx_loaded_q <= 1'b0;
            io_rdata_q <= 16'h0000;
            irq_q <= 1'b0;
            rx_copy_q <= 1'b0;
            tx_copy_q <= 1'b0;
            tx_hold_q <= 1'b0;
            stop_gen_q <= 1'b0;
            mst_clr_q <= 1'b0;
        end
        else
        begin
            ier_q <= ier_d;
            str_q <= str_d;
            tx_loaded_q <= tx_loaded_d;
            io_rdata_q <= rdata_d;
            irq_q <= irq_d;
            rx_copy_q <= rx_copy_d;
            tx_copy_q <= tx_copy_d;
            tx_hold_q <= tx_hold_d;
            stop_gen_q <= stop_gen_d;
            mst_clr_q <= mst_clr_d;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_starve;
        module_enable && ev[EV_TX_EMPTY] && !tx_loaded_q && !tx_hold_q && !tx_data_wr;
    endsequence
    sequence s_held;
        !str_q[ST_TX_NOT_EMPTY] && tx_hold_q;
    endsequence

    tx_starve_a: assert property (s_starve |=> s_held)
        else $error("underflow did not hold transfer");
    tx_resume_a: assert property (module_enable && tx_hold_q && tx_data_wr && !ev[EV_TX_EMPTY]
        ##1 module_enable |=> tx_copy_q && str_q[ST_TX_READY])
        else $error("starved transmit did not resume");
    rx_overrun_a: assert property (module_enable && ev[EV_RX_BYTE] && str_q[ST_RX_READY]
        && !rx_data_rd |=> str_q[ST_RX_OVERRUN] && !rx_copy_q)
        else $error("overrun not flagged");
    rx_ready_a: assert property (module_enable && ev[EV_RX_BYTE] && !str_q[ST_RX_READY]
        |=> str_q[ST_RX_READY] && rx_copy_q)
        else $error("receive ready not set");
    w1c_busy_a: assert property (module_enable && io_wr && io_addr == STR_OFS
        && io_wdata[ST_BUS_BUSY] && !ev[EV_START] |=> !str_q[ST_BUS_BUSY])
        else $error("bus busy not cleared by write");
    ier_reserved_a: assert property (io_rd && io_addr == IER_OFS
        |=> io_rdata_q[15:5] == 11'h000)
        else $error("reserved enable bits not zero");
    disable_dflt_a: assert property (!module_enable |=> str_q == STR_RESET
        && !mst_clr_q && !stop_gen_q)
        else $error("disable did not restore defaults");
    arb_drop_a: assert property (module_enable && ev[EV_ARB_LOST]
        |=> str_q[ST_ARB_LOST] && mst_clr_q)
        else $error("arbitration loss not handled");
    stop_gen_a: assert property (module_enable && master_mode && ev[EV_CNT_ZERO]
        && !repeat_mode && stop_request && !str_q[ST_ACC_READY] && !ev[EV_TX_BYTE_END]
        |=> stop_gen_q && !str_q[ST_ACC_READY])
        else $error("count zero with stop request wrong");
    irq_gate_a: assert property (|(ier_q & str_view[4:0]) |=> irq_q)
        else $error("enabled flag raised no interrupt");
    gc_noack_a: assert property (gc_xfer && io_rd && io_addr == STR_OFS
        |=> io_rdata_q[ST_NOACK])
        else $error("general call no-ack not reported");
endmodule

// ==== verif/i2c_irq_enable_status_test.sv ====
`timescale 1ns/1ps
module i2c_irq_enable_status_test
    import i2cie_pkg::*;
;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic arst_n;
    logic [3:0] io_addr = 4'h0;
    logic io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_wdata = 16'h0;
    logic [15:0] io_rdata_q, v;
    logic module_enable = 1'b1, master_mode = 1'b0, repeat_mode = 1'b0;
    logic stop_request = 1'b0, addr_10bit = 1'b0, gc_xfer = 1'b0;
    logic start_req = 1'b0, tx_data_wr = 1'b0, rx_data_rd = 1'b0;
    logic [NUM_EV-1:0] lk;
    logic irq_q, rx_copy_q, tx_copy_q, tx_hold_q, stop_gen_q, mst_clr_q;
    int failures = 0;
    int checks_done = 0;
    int cnt [4];

    // Module clock; link clock offset so the two never line up
    always #2 mclk = ~mclk;
    initial
    begin
        #5;
        forever #16 lclk = ~lclk;
    end

    i2cie_link_model LNK (.lclk, .ev(lk));

    i2cie_top DUT (
        .mclk, .arst_n, .lclk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q,
        .module_enable, .master_mode, .repeat_mode, .stop_request, .addr_10bit,
        .gc_xfer, .start_req, .tx_data_wr, .rx_data_rd,
        .lk_start(lk[EV_START]), .lk_stop(lk[EV_STOP]), .lk_nack_sent(lk[EV_NACK_SENT]),
        .lk_ack_rx(lk[EV_ACK_RX]), .lk_nack_rx(lk[EV_NACK_RX]),
        .lk_own_addr(lk[EV_OWN_ADDR]), .lk_gcall_addr(lk[EV_GCALL_ADDR]),
        .lk_free_first(lk[EV_FREE_FIRST]), .lk_addr_diff(lk[EV_ADDR_DIFF]),
        .lk_rx_byte(lk[EV_RX_BYTE]), .lk_tx_empty(lk[EV_TX_EMPTY]),
        .lk_cnt_zero(lk[EV_CNT_ZERO]), .lk_tx_byte_end(lk[EV_TX_BYTE_END]),
        .lk_arb_lost(lk[EV_ARB_LOST]), .lk_reg_use(lk[EV_REG_USE]),
        .irq_q, .rx_copy_q, .tx_copy_q, .tx_hold_q, .stop_gen_q, .mst_clr_q
    );

    // Tally one-cycle pulses so they need no exact timing in the tests
    always @(posedge mclk)
    begin
        if (rx_copy_q === 1'b1) cnt[0]++;
        if (tx_copy_q === 1'b1) cnt[1]++;
        if (stop_gen_q === 1'b1) cnt[2]++;
        if (mst_clr_q === 1'b1) cnt[3]++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register port: strobe held one edge, then settle time for the flags
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge mclk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata_q;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a, v);
        chk(v, e, "register");
    endtask

    task automatic st(input logic [15:0] m, input logic [15:0] e);
        rd(STR_OFS, v);
        chk(v & m, e, "status");
    endtask

    task automatic wst(input logic [15:0] d, input logic [15:0] m, input logic [15:0] e);
        wr(STR_OFS, d);
        st(m, e);
    endtask

    // Link event, then long enough for the crossing to land
    task automatic lst(input int e, input logic [15:0] m, input logic [15:0] x);
        LNK.send(e);
        repeat (8) @(posedge mclk);
        st(m, x);
    endtask

    // 0 start attempt, 1 tx data written, 2 rx data read
    task automatic sst(input int k, input logic [15:0] m, input logic [15:0] x);
        @(posedge mclk);
        start_req <= (k == 0);
        tx_data_wr <= (k == 1);
        rx_data_rd <= (k == 2);
        @(posedge mclk);
        start_req <= 1'b0;
        tx_data_wr <= 1'b0;
        rx_data_rd <= 1'b0;
        repeat (3) @(posedge mclk);
        st(m, x);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog; the tests need under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        // Real falling edge, since no link clock edge lands inside reset
        #1;
        arst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        // Reset values, widths, reserved and unmapped places
        rchk(IER_OFS, 16'h0000);
        st(16'hffff, 16'h0410);
        rchk(ISRC_OFS, 16'h0000);
        wr(IER_OFS, 16'hffff);
        rchk(IER_OFS, 16'h001f);
        wst(16'hc0e0, 16'hffff, 16'h0410);
        rchk(4'h7, 16'h0000);
        done("registers");
        // Transmit copy, underflow and release
        sst(1, 16'h0010, 16'h0000);
        lst(EV_TX_EMPTY, 16'h0410, 16'h0410);
        lst(EV_TX_EMPTY, 16'h0400, 16'h0000);
        chk(16'(tx_hold_q), 16'h1, "hold");
        sst(1, 16'h0410, 16'h0410);
        chk(16'(tx_hold_q), 16'h0, "hold");
        chk(16'(cnt[1]), 16'h2, "tx copies");
        wst(16'h0010, 16'h0010, 16'h0000);
        done("transmit");
        // Bus busy
        lst(EV_START, 16'h1000, 16'h1000);
        wst(16'h0000, 16'h1000, 16'h1000);
        lst(EV_STOP, 16'h1000, 16'h0000);
        lst(EV_START, 16'h1000, 16'h1000);
        wst(16'h1000, 16'h1000, 16'h0000);
        done("busy");
        // Receive, overrun, masking of the request
        lst(EV_RX_BYTE, 16'h0808, 16'h0008);
        lst(EV_RX_BYTE, 16'h0808, 16'h0808);
        sst(2, 16'h0808, 16'h0008);
        chk(16'(cnt[0]), 16'h2, "rx copies");
        wr(IER_OFS, 16'h0008);
        chk(16'(irq_q), 16'h1, "irq");
        rchk(ISRC_OFS, 16'h0004);
        wr(IER_OFS, 16'h0017);
        chk(16'(irq_q), 16'h0, "irq");
        wr(IER_OFS, 16'h0000);
        sst(2, 16'h0008, 16'h0000);
        done("receive");
        // Access ready, counter end with and without stop, repeat mode
        @(posedge mclk);
        master_mode <= 1'b1;
        lst(EV_CNT_ZERO, 16'h0004, 16'h0004);
        lst(EV_REG_USE, 16'h0004, 16'h0000);
        @(posedge mclk);
        stop_request <= 1'b1;
        lst(EV_CNT_ZERO, 16'h0004, 16'h0000);
        chk(16'(cnt[2]), 16'h1, "stop");
        @(posedge mclk);
        stop_request <= 1'b0;
        repeat_mode <= 1'b1;
        lst(EV_TX_BYTE_END, 16'h0004, 16'h0004);
        wst(16'h0004, 16'h0004, 16'h0000);
        @(posedge mclk);
        master_mode <= 1'b0;
        lst(EV_TX_BYTE_END, 16'h0004, 16'h0000);
        @(posedge mclk);
        repeat_mode <= 1'b0;
        done("access");
        // No-acknowledge, source read, general call
        lst(EV_NACK_RX, 16'h0002, 16'h0002);
        lst(EV_ACK_RX, 16'h0002, 16'h0000);
        lst(EV_NACK_RX, 16'h0002, 16'h0002);
        wr(IER_OFS, 16'h0002);
        rchk(ISRC_OFS, 16'h0002);
        st(16'h0002, 16'h0000);
        @(posedge mclk);
        gc_xfer <= 1'b1;
        repeat (3) @(posedge mclk);
        st(16'h0002, 16'h0002);
        chk(16'(irq_q), 16'h1, "irq");
        @(posedge mclk);
        gc_xfer <= 1'b0;
        // Arbitration lost by contest and by start while busy
        lst(EV_ARB_LOST, 16'h0001, 16'h0001);
        chk(16'(cnt[3]), 16'h1, "master clear");
        wr(IER_OFS, 16'h0001);
        rchk(ISRC_OFS, 16'h0001);
        st(16'h0001, 16'h0000);
        lst(EV_START, 16'h1000, 16'h1000);
        sst(0, 16'h0001, 16'h0001);
        chk(16'(cnt[3]), 16'h2, "master clear");
        wst(16'h1001, 16'h1001, 16'h0000);
        wr(IER_OFS, 16'h0000);
        lst(EV_NACK_SENT, 16'h2000, 16'h2000);
        wst(16'h2000, 16'h2000, 16'h0000);
        done("acknowledge");
        // Addressed as target, seven and ten bit addressing
        lst(EV_OWN_ADDR, 16'h0200, 16'h0200);
        lst(EV_STOP, 16'h0200, 16'h0000);
        lst(EV_GCALL_ADDR, 16'h0300, 16'h0300);
        lst(EV_START, 16'h0300, 16'h0200);
        lst(EV_START, 16'h0200, 16'h0000);
        @(posedge mclk);
        addr_10bit <= 1'b1;
        lst(EV_OWN_ADDR, 16'h0200, 16'h0200);
        lst(EV_ADDR_DIFF, 16'h0200, 16'h0000);
        lst(EV_FREE_FIRST, 16'h0200, 16'h0200);
        lst(EV_NACK_RX, 16'h0200, 16'h0000);
        @(posedge mclk);
        addr_10bit <= 1'b0;
        done("addressing");
        // Module disable returns status to defaults and ignores the link
        lst(EV_NACK_SENT, 16'h2000, 16'h2000);
        wr(IER_OFS, 16'h001f);
        @(posedge mclk);
        module_enable <= 1'b0;
        repeat (3) @(posedge mclk);
        st(16'hffff, 16'h0410);
        rchk(IER_OFS, 16'h001f);
        lst(EV_START, 16'hffff, 16'h0410);
        @(posedge mclk);
        module_enable <= 1'b1;
        done("disable");
        end_sim();
    end
endmodule

// ==== verif/i2cie_link_model.sv ====
`timescale 1ns/1ps
// Far-side bus activity, seen by the block as one-cycle link events
module i2cie_link_model
    import i2cie_pkg::*;
(
    input wire logic lclk, // Link clock
    output logic [NUM_EV-1:0] ev // Event pulses, link domain
);
    initial ev = '0;

    // One event per call, launched on an edge and held one full link cycle
    task automatic send(input int idx);
        @(posedge lclk);
        ev[idx] <= 1'b1;
        @(posedge lclk);
        ev[idx] <= 1'b0;
    endtask
endmodule
